// [common/lpm_if.sv]
// Pin-level link between the controller and its power supervisor
interface lpm_if;
  logic reset_n;
  logic single_step_n;
  logic power_save_n;
  logic ext_interrupt_n;
  logic ext_access;
  logic osc_running;
  logic osc_out;
  logic osc_in_oe;
  logic addr_latch_en;
  logic data_bus_oe;
  logic strobes_oe;
  logic counter_in0_oe;
  logic pullup_en;
  modport device (
    input reset_n, single_step_n, power_save_n, ext_interrupt_n,
    input ext_access,
    output osc_running, osc_out, osc_in_oe, addr_latch_en,
    output data_bus_oe, strobes_oe, counter_in0_oe, pullup_en
  );
  modport supervisor (
    output reset_n, single_step_n, power_save_n, ext_interrupt_n,
    output ext_access,
    input osc_running, osc_out, osc_in_oe, addr_latch_en,
    input data_bus_oe, strobes_oe, counter_in0_oe, pullup_en
  );
endinterface

// [common/lpm_pkg.sv]
// Shared constants and types for the low-power mode control link
package lpm_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int RST_SETUP_US = 10;
  localparam int RST_HOLD_US = 10;
  localparam int SS_SETUP_MS = 10;
  localparam int SS_HOLD_US = 10;
  localparam int RST_SETUP_CYC = RST_SETUP_US * CLK_MHZ;
  localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
  localparam int SS_SETUP_CYC = SS_SETUP_MS * 1000 * CLK_MHZ;
  localparam int SS_HOLD_CYC = SS_HOLD_US * CLK_MHZ;
  localparam int CNT_W = 22;
  // ----------------------------------------
  // Opcodes and addresses
  // ----------------------------------------
  localparam logic [7:0] OP_HALT = 8'h01;
  localparam logic [11:0] RESET_ADDR = 12'h000;
  localparam logic [11:0] IRQ_ADDR = 12'h003;
  localparam logic [11:0] PC_STEP = 12'h001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [2:0] {
    DV_RUN, DV_HALT, DV_IRQ_STEP, DV_PD_RAM, DV_PD_ALL, DV_WAIT
  } lpm_dev_state_t;
  typedef enum logic [2:0] {
    SV_IDLE, SV_RAM_SETUP, SV_RAM_PD, SV_RAM_HOLD,
    SV_ALL_SETUP, SV_ALL_PD, SV_ALL_HOLD
  } lpm_sup_state_t;
endpackage

// [test/lpm_checker.sv]
// Link checker for the power-down and wake-up pin sequencing
module lpm_checker (
  input wire logic clock,
  input wire logic sys_reset_n,
  input wire logic reset_n,
  input wire logic single_step_n,
  input wire logic power_save_n,
  input wire logic osc_running,
  input wire logic osc_out,
  input wire logic osc_in_oe,
  input wire logic data_bus_oe,
  input wire logic strobes_oe,
  input wire logic counter_in0_oe,
  input wire logic pullup_en
);
  // ----------------------------------------
  // Level age counters
  // ----------------------------------------
  int rst_lo_r;
  int ss_lo_r;
  int ps_hi_r;
  // Wide enough for the step setup time
  always_ff @(posedge clock) begin
    rst_lo_r <= reset_n ? 0 : rst_lo_r + 1;
    ss_lo_r <= single_step_n ? 0 : ss_lo_r + 1;
    ps_hi_r <= power_save_n ? ps_hi_r + 1 : 0;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!sys_reset_n);
  // ----------------------------------------
  // Pin order and timing
  // ----------------------------------------
  AST_RAM_SETUP: assert property ($fell(power_save_n) && !reset_n
    |-> rst_lo_r >= lpm_pkg::RST_SETUP_CYC) else $error("reset setup short");
  AST_RAM_HOLD: assert property ($rose(reset_n)
    |-> ps_hi_r >= lpm_pkg::RST_HOLD_CYC) else $error("reset hold short");
  AST_ALL_SETUP: assert property ($fell(power_save_n) && reset_n
    |-> ss_lo_r >= lpm_pkg::SS_SETUP_CYC) else $error("step setup short");
  AST_ALL_HOLD: assert property ($rose(single_step_n)
    |-> ps_hi_r >= lpm_pkg::SS_HOLD_CYC) else $error("step hold short");
  AST_STOP: assert property ($fell(power_save_n)
    |-> ##[1:3] !osc_running) else $error("oscillator did not stop");
  AST_START: assert property ($rose(power_save_n)
    |-> ##[1:3] osc_running) else $error("oscillator did not restart");
  AST_NO_STOP: assert property (power_save_n && osc_running
    |=> osc_running) else $error("oscillator stopped unasked");
  AST_FLOAT: assert property (!osc_running
    |-> !data_bus_oe && !strobes_oe && !counter_in0_oe && !osc_in_oe
    && osc_out) else $error("pins not floated in power-down");
  AST_PULLUP: assert property (!osc_running
    |-> !pullup_en) else $error("pull-ups on while stopped");
endmodule // lpm_checker

// [test/tb_mcu_low_power_mode_control.sv]
// Bench for the controller and supervisor joined by their link
module tb_mcu_low_power_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic cpu_reset_n = 1'h0;
  logic irq_n = 1'h1;
  logic instr_done = 1'h0;
  logic irq_enable_set = 1'h0;
  logic irq_enable_clr = 1'h0;
  logic req_ram_pd = 1'h0;
  logic req_wake = 1'h0;
  logic req_all_pd = 1'h0;
  logic [7:0] opcode = 8'h00;
  logic [11:0] expander_strobe_addr;
  logic [11:0] a;
  logic cpu_clk_en, irq_enabled_state, irq_service, halted, powered_down;
  logic busy;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int svc = 0;
  lpm_if lnk ();
  lpm_device lpm_device_i (.clock(clock), .lnk(lnk), .opcode(opcode),
    .instr_done(instr_done), .irq_enable_set(irq_enable_set),
    .irq_enable_clr(irq_enable_clr), .expander_strobe_addr(expander_strobe_addr),
    .cpu_clk_en(cpu_clk_en), .irq_enabled_state(irq_enabled_state),
    .irq_service(irq_service), .halted(halted),
    .powered_down(powered_down));
  // Full-state entry needs 2M cycles: only its step wait is run here
  lpm_supervisor lpm_supervisor_i (.clock(clock), .reset_n(reset_n),
    .lnk(lnk), .req_ram_pd(req_ram_pd), .req_all_pd(req_all_pd),
    .req_wake(req_wake), .cpu_reset_n(cpu_reset_n), .irq_n(irq_n),
    .busy(busy));
  lpm_checker lpm_checker_i (.clock(clock), .sys_reset_n(reset_n),
    .reset_n(lnk.reset_n), .single_step_n(lnk.single_step_n),
    .power_save_n(lnk.power_save_n), .osc_running(lnk.osc_running),
    .osc_out(lnk.osc_out), .osc_in_oe(lnk.osc_in_oe),
    .data_bus_oe(lnk.data_bus_oe), .strobes_oe(lnk.strobes_oe),
    .counter_in0_oe(lnk.counter_in0_oe), .pullup_en(lnk.pullup_en));
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (irq_service === 1'h1) svc++;
    if (cycles == 12000) begin
      failures++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [11:0] e,
    input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic instr(input logic [7:0] op);
    opcode = op;
    instr_done = 1'h1;
    cyc(1);
    instr_done = 1'h0;
    cyc(2);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_halt_di();
    instr(lpm_pkg::OP_HALT);
    chk("halted", 12'h001, halted);
    a = expander_strobe_addr;
    cyc(5);
    chk("pc", a, expander_strobe_addr);
    chk("clk_en", 12'h000, cpu_clk_en);
    chk("ale", 12'h000, lnk.addr_latch_en);
    chk("strobes", 12'h001, lnk.strobes_oe);
    irq_n = 1'h0;
    cyc(3);
    irq_n = 1'h1;
    chk("halted", 12'h000, halted);
    instr(8'h00);
    cyc(2);
    chk("svc", 12'h000, 12'(svc));
    chk("pc", a + lpm_pkg::PC_STEP, expander_strobe_addr);
    $display("halt_di done");
  endtask
  task automatic t_halt_ei();
    irq_enable_set = 1'h1;
    cyc(1);
    irq_enable_set = 1'h0;
    cyc(2);
    chk("ie", 12'h001, irq_enabled_state);
    // Moves the halt off the service address so the jump shows
    instr(8'h00);
    instr(lpm_pkg::OP_HALT);
    irq_n = 1'h0;
    cyc(3);
    chk("svc", 12'h000, 12'(svc));
    chk("clk_en", 12'h001, cpu_clk_en);
    instr(8'h00);
    cyc(2);
    irq_n = 1'h1;
    chk("svc", 12'h001, 12'(svc));
    chk("pc", lpm_pkg::IRQ_ADDR, expander_strobe_addr);
    $display("halt_ei done");
  endtask
  task automatic t_halt_rst();
    instr(lpm_pkg::OP_HALT);
    cpu_reset_n = 1'h0;
    cyc(3);
    cpu_reset_n = 1'h1;
    cyc(3);
    chk("halted", 12'h000, halted);
    chk("pc", lpm_pkg::RESET_ADDR, expander_strobe_addr);
    chk("ie", 12'h000, irq_enabled_state);
    $display("halt_rst done");
  endtask
  task automatic t_step();
    req_all_pd = 1'h1;
    cyc(1);
    req_all_pd = 1'h0;
    cyc(2);
    chk("step", 12'h000, lnk.single_step_n);
    chk("busy", 12'h001, busy);
    chk("clk_en", 12'h001, cpu_clk_en);
    instr(8'h00);
    a = expander_strobe_addr;
    chk("clk_en", 12'h000, cpu_clk_en);
    cyc(4);
    chk("pc", a, expander_strobe_addr);
    chk("pd", 12'h000, powered_down);
    // Mid-run reset aborts the long full-state setup wait
    reset_n = 1'h0;
    cyc(2);
    reset_n = 1'h1;
    cyc(4);
    chk("step", 12'h001, lnk.single_step_n);
    chk("pc", lpm_pkg::RESET_ADDR, expander_strobe_addr);
    chk("clk_en", 12'h001, cpu_clk_en);
    chk("busy", 12'h000, busy);
    $display("step done");
  endtask
  task automatic t_ram_pd();
    instr(8'h00);
    instr(8'h00);
    req_ram_pd = 1'h1;
    cyc(1);
    req_ram_pd = 1'h0;
    cyc(lpm_pkg::RST_SETUP_CYC + 5);
    chk("pd", 12'h001, powered_down);
    irq_n = 1'h0;
    cyc(3);
    irq_n = 1'h1;
    chk("pd", 12'h001, powered_down);
    req_wake = 1'h1;
    cyc(1);
    req_wake = 1'h0;
    cyc(lpm_pkg::RST_HOLD_CYC + 10);
    chk("pd", 12'h000, powered_down);
    chk("busy", 12'h000, busy);
    chk("pc", lpm_pkg::RESET_ADDR, expander_strobe_addr);
    $display("ram_pd done");
  endtask
  initial begin
    cyc(10);
    reset_n = 1'h1;
    // Link reset stays low long enough for the power-save hold time
    cyc(2100);
    cpu_reset_n = 1'h1;
    cyc(4);
    chk("pc", lpm_pkg::RESET_ADDR, expander_strobe_addr);
    chk("ie", 12'h000, irq_enabled_state);
    t_halt_di();
    t_halt_ei();
    t_halt_rst();
    t_step();
    t_ram_pd();
    print_verdict();
  end
endmodule // tb_mcu_low_power_mode_control

// [verilog/lpm_device.sv]
// Controller end: run, halt, single step and power-down sequencing
// Function
// - Reset then power_save low stops oscillator
// - Power_save high then reset restarts at 0
// - Reset low 10 us before power_save
// - Reset low 10 us after power_save
// - Single_step then power_save low stops oscillator
// - Exit resumes from held state
// - Single_step low 10 ms before power_save
// - Single_step low 10 us after power_save
// - Opcode 01H enters halt
// - Halt keeps oscillator, freezes internal state (code holds pc but irq_enable_set and irq_enable_clr still change ie)
// - Reset during halt restarts at 000H
// - Enabled interrupt: one instruction, then service
// - Disabled interrupt: continue after halt
// - Power-down floats bus, pins, osc_out high
// - Stopped oscillator ignores reset, step, interrupt
// - Halt holds outputs, strobes high, latch low
// - Power_save is active-low power request
// - Single_step low waits after instruction
// - Reset clears interrupt enable
module lpm_device (
  input wire logic clock,
  lpm_if.device lnk,
  input wire logic [7:0] opcode,
  input wire logic instr_done,
  input wire logic irq_enable_set,
  input wire logic irq_enable_clr,
  output logic [11:0] expander_strobe_addr,
  output logic cpu_clk_en,
  output logic irq_enabled_state,
  output logic irq_service,
  output logic halted,
  output logic powered_down
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  lpm_pkg::lpm_dev_state_t st_r, st_nxt;
  logic [11:0] pc_r, pc_nxt;
  logic ie_r, ie_nxt;
  logic svc_r, svc_nxt;
  logic osc_r, osc_nxt;
  logic ale_r, ale_nxt;
  logic bus_oe_r, bus_oe_nxt;
  logic strb_oe_r, strb_oe_nxt;
  logic t0_oe_r, t0_oe_nxt;
  logic run_r, run_nxt;
  logic halt_r, halt_nxt;
  logic pd_r, pd_nxt;
  logic stopped;
  // Stopped oscillator: only power_save_n is sampled
  assign stopped = (st_r == lpm_pkg::DV_PD_RAM) ||
                   (st_r == lpm_pkg::DV_PD_ALL);
  // ----------------------------------------
  // Next state: run control
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    ie_nxt = ie_r;
    svc_nxt = 1'b0;
    run_nxt = 1'b1;
    ale_nxt = 1'b0;
    // No instruction runs with the oscillator off
    if (irq_enable_set && !stopped) begin
      ie_nxt = 1'b1;
    end else if (irq_enable_clr && !stopped) begin
      ie_nxt = 1'b0;
    end
    case (st_r)
      lpm_pkg::DV_RUN: begin
        ale_nxt = instr_done;
        if (instr_done) begin
          pc_nxt = pc_r + lpm_pkg::PC_STEP;
        end
        if (!lnk.reset_n) begin
          pc_nxt = lpm_pkg::RESET_ADDR;
          ie_nxt = 1'b0;
          run_nxt = 1'b0;
          if (!lnk.power_save_n) begin
            st_nxt = lpm_pkg::DV_PD_RAM;
          end
        end else if (instr_done && opcode == lpm_pkg::OP_HALT) begin
          st_nxt = lpm_pkg::DV_HALT;
        end else if (!lnk.single_step_n && instr_done) begin
          // Step waits only at an instruction boundary
          st_nxt = lpm_pkg::DV_WAIT;
        end
      end
      lpm_pkg::DV_WAIT: begin
        run_nxt = 1'b0;
        if (!lnk.reset_n) begin
          pc_nxt = lpm_pkg::RESET_ADDR;
          ie_nxt = 1'b0;
          st_nxt = lpm_pkg::DV_RUN;
        end else if (!lnk.power_save_n) begin
          // Full-state entry only from a step wait
          st_nxt = lpm_pkg::DV_PD_ALL;
        end else if (lnk.single_step_n) begin
          st_nxt = lpm_pkg::DV_RUN;
        end
      end
      lpm_pkg::DV_HALT: begin
        run_nxt = 1'b0;
        if (!lnk.reset_n) begin
          pc_nxt = lpm_pkg::RESET_ADDR;
          ie_nxt = 1'b0;
          st_nxt = lpm_pkg::DV_RUN;
        end else if (!lnk.ext_interrupt_n) begin
          // Read on the free clock, so a halt can end
          st_nxt = ie_r ? lpm_pkg::DV_IRQ_STEP
                        : lpm_pkg::DV_RUN;
        end
      end
      lpm_pkg::DV_IRQ_STEP: begin
        // Reset still wins over the pending service entry
        if (!lnk.reset_n) begin
          pc_nxt = lpm_pkg::RESET_ADDR;
          ie_nxt = 1'b0;
          st_nxt = lpm_pkg::DV_RUN;
        end else if (instr_done) begin
          pc_nxt = lpm_pkg::IRQ_ADDR;
          svc_nxt = 1'b1;
          st_nxt = lpm_pkg::DV_RUN;
        end
      end
      lpm_pkg::DV_PD_RAM: begin
        // Oscillator off: only power_save_n is watched
        run_nxt = 1'b0;
        if (lnk.power_save_n) begin
          st_nxt = lpm_pkg::DV_RUN;
        end
      end
      lpm_pkg::DV_PD_ALL: begin
        run_nxt = 1'b0;
        if (lnk.power_save_n) begin
          st_nxt = lpm_pkg::DV_WAIT;
        end
      end
      default: begin
        st_nxt = lpm_pkg::DV_RUN;
      end
    endcase
    if (st_nxt == lpm_pkg::DV_HALT) begin
      ale_nxt = 1'b0;
    end
  end
  // ----------------------------------------
  // Next state: pin drive
  // ----------------------------------------
  // Pins follow the next state so they change with it, not a cycle late
  always_comb begin
    osc_nxt = !((st_nxt == lpm_pkg::DV_PD_RAM) ||
                (st_nxt == lpm_pkg::DV_PD_ALL));
    bus_oe_nxt = osc_nxt;
    strb_oe_nxt = osc_nxt;
    t0_oe_nxt = osc_nxt;
    halt_nxt = (st_nxt == lpm_pkg::DV_HALT);
    pd_nxt = !osc_nxt;
  end
  // ----------------------------------------
  // Registers: run control
  // ----------------------------------------
  // No reset term: the link reset pin is decoded in the next-state logic
  // Power-down leaves pc and ie untouched; halt holds pc but still lets irq_enable_set and irq_enable_clr change ie
  always_ff @(posedge clock) begin
    st_r <= st_nxt;
    pc_r <= pc_nxt;
    ie_r <= ie_nxt;
    svc_r <= svc_nxt;
    run_r <= run_nxt;
    ale_r <= ale_nxt;
  end
  // ----------------------------------------
  // Registers: pin drive
  // ----------------------------------------
  always_ff @(posedge clock) begin
    osc_r <= osc_nxt;
    bus_oe_r <= bus_oe_nxt;
    strb_oe_r <= strb_oe_nxt;
    t0_oe_r <= t0_oe_nxt;
    halt_r <= halt_nxt;
    pd_r <= pd_nxt;
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Oscillator output idles high whenever the oscillator is stopped
  assign lnk.osc_running = osc_r;
  assign lnk.osc_out = 1'b1;
  assign lnk.osc_in_oe = 1'b0;
  assign lnk.addr_latch_en = ale_r;
  assign lnk.data_bus_oe = bus_oe_r;
  assign lnk.strobes_oe = strb_oe_r;
  assign lnk.counter_in0_oe = t0_oe_r;
  assign lnk.pullup_en = osc_r;
  assign expander_strobe_addr = pc_r;
  assign cpu_clk_en = run_r;
  assign irq_enabled_state = ie_r;
  assign irq_service = svc_r;
  assign halted = halt_r;
  assign powered_down = pd_r;
endmodule // lpm_device

// [verilog/lpm_supervisor.sv]
// Supervisor end: orders reset, single_step and power_save pins
module lpm_supervisor (
  input wire logic clock,
  input wire logic reset_n,
  lpm_if.supervisor lnk,
  input wire logic req_ram_pd,
  input wire logic req_all_pd,
  input wire logic req_wake,
  input wire logic cpu_reset_n,
  input wire logic irq_n,
  output logic busy
);
  lpm_pkg::lpm_sup_state_t st_r, st_nxt;
  logic rst_r, rst_nxt, ss_r, ss_nxt, ps_r, ps_nxt;
  logic busy_r, busy_nxt;
  logic load;
  logic [lpm_pkg::CNT_W-1:0] value;
  logic done;
  lpm_wait_cnt u_cnt (
    .clock(clock),
    .reset_n(reset_n),
    .load(load),
    .value(value),
    .done(done)
  );
  always_comb begin
    st_nxt = st_r;
    rst_nxt = rst_r;
    ss_nxt = ss_r;
    ps_nxt = ps_r;
    load = 1'b0;
    value = '0;
    case (st_r)
      lpm_pkg::SV_IDLE: begin
        rst_nxt = cpu_reset_n;
        if (req_ram_pd) begin
          rst_nxt = 1'b0;
          load = 1'b1;
          value = lpm_pkg::CNT_W'(lpm_pkg::RST_SETUP_CYC);
          st_nxt = lpm_pkg::SV_RAM_SETUP;
        end else if (req_all_pd) begin
          ss_nxt = 1'b0;
          load = 1'b1;
          value = lpm_pkg::CNT_W'(lpm_pkg::SS_SETUP_CYC);
          st_nxt = lpm_pkg::SV_ALL_SETUP;
        end
      end
      lpm_pkg::SV_RAM_SETUP: if (done) begin
        ps_nxt = 1'b0;
        st_nxt = lpm_pkg::SV_RAM_PD;
      end
      lpm_pkg::SV_RAM_PD: if (req_wake) begin
        ps_nxt = 1'b1;
        load = 1'b1;
        value = lpm_pkg::CNT_W'(lpm_pkg::RST_HOLD_CYC);
        st_nxt = lpm_pkg::SV_RAM_HOLD;
      end
      lpm_pkg::SV_RAM_HOLD: if (done) begin
        rst_nxt = 1'b1;
        st_nxt = lpm_pkg::SV_IDLE;
      end
      lpm_pkg::SV_ALL_SETUP: if (done) begin
        ps_nxt = 1'b0;
        st_nxt = lpm_pkg::SV_ALL_PD;
      end
      lpm_pkg::SV_ALL_PD: if (req_wake) begin
        ps_nxt = 1'b1;
        load = 1'b1;
        value = lpm_pkg::CNT_W'(lpm_pkg::SS_HOLD_CYC);
        st_nxt = lpm_pkg::SV_ALL_HOLD;
      end
      lpm_pkg::SV_ALL_HOLD: if (done) begin
        ss_nxt = 1'b1;
        st_nxt = lpm_pkg::SV_IDLE;
      end
      default: st_nxt = lpm_pkg::SV_IDLE;
    endcase
    busy_nxt = (st_nxt != lpm_pkg::SV_IDLE);
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r <= lpm_pkg::SV_IDLE;
      rst_r <= 1'b0;
      ss_r <= 1'b1;
      ps_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      rst_r <= rst_nxt;
      ss_r <= ss_nxt;
      ps_r <= ps_nxt;
      busy_r <= busy_nxt;
    end
  end
  assign lnk.reset_n = rst_r;
  assign lnk.single_step_n = ss_r;
  assign lnk.power_save_n = ps_r;
  assign lnk.ext_interrupt_n = irq_n;
  assign lnk.ext_access = 1'b0;
  assign busy = busy_r;
endmodule // lpm_supervisor

// [verilog/lpm_wait_cnt.sv]
// Down-counter for least hold and setup times
module lpm_wait_cnt (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [lpm_pkg::CNT_W-1:0] value,
  output logic done
);
  logic [lpm_pkg::CNT_W-1:0] cnt_r;
  logic [lpm_pkg::CNT_W-1:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = value;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign done = (cnt_r == '0) && !load;
endmodule // lpm_wait_cnt
